//--- verilog/flash_id_host.sv
// Host controller for identification mode and reset of a parallel NOR flash
// Assumes asynchronous flash pins; data input comes from outside the clock domain
`timescale 1ns/100ps
module flash_id_host
  import flash_id_pkg::*;
#(
  parameter int ADDR_W = 22
) (
  input  wire logic              clk,
  input  wire logic              rst,
  // User side
  input  wire logic              op_valid,
  output logic                   op_ready,
  input  wire logic [2:0]        op_code,
  input  wire logic [ADDR_W-1:0] op_addr,
  input  wire logic              word_mode,
  input  wire logic              hv_id_en,
  output logic                   rsp_valid,
  output logic [15:0]            rsp_data,
  output logic                   rsp_err,
  output logic                   id_mode,
  output logic                   fail_seen,
  // Flash pins
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [15:0]            flash_dq_out,
  output logic                   flash_dq_oe,
  input  wire logic [15:0]       flash_dq_in,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n,
  output logic                   flash_reset_n,
  output logic                   flash_byte_n,
  output logic                   high_voltage_select_pin
);

  // Unlock offsets need 12 address bits; wider than 32 is not served
  if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie in 12..32");
  end

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_SETUP  = 3'b001,
    S_STROBE = 3'b011,
    S_RECOV  = 3'b010,
    S_RDWAIT = 3'b110,
    S_RST    = 3'b111,
    S_RSTREC = 3'b101
  } state_t;

  state_t              state_reg;
  op_t                 op_reg;
  logic [1:0]          step_reg;
  logic [1:0]          nwr_reg;
  logic                rd_after_reg;
  logic [ADDR_W-1:0]   rd_addr_reg;
  logic [15:0]         dq_meta_reg;
  logic [15:0]         dq_sync_reg;
  logic                tmr_start;
  logic [7:0]          tmr_load;
  logic                tmr_done;
  logic                take;
  logic                refuse;
  logic [7:0]          last_wr_reg;
  logic [7:0]          prev_wr_reg;

  cycle_timer u_timer (
    .clk   (clk),
    .rst   (rst),
    .start (tmr_start),
    .load  (tmr_load),
    .done  (tmr_done)
  );

  // Unlock and command address for each write step
  function automatic logic [ADDR_W-1:0] seq_addr(input logic [1:0] step, input logic wm, input op_t op);
    logic [11:0] a;
    a = 12'h000;
    if (op == OP_RESET)
      a = 12'h000;
    else if (step == 2'h1)
      a = wm ? UNLOCK2_WORD : UNLOCK2_BYTE;
    else
      a = wm ? UNLOCK1_WORD : UNLOCK1_BYTE;
    seq_addr = ADDR_W'(a);
  endfunction

  // Data byte for each write step
  function automatic logic [7:0] seq_data(input logic [1:0] step, input op_t op);
    logic [7:0] d;
    d = CMD_RESET;
    if (op == OP_ENTER_ID) begin
      unique case (step)
        2'h0:    d = UNLOCK1_DATA;
        2'h1:    d = UNLOCK2_DATA;
        default: d = CMD_ID_ENTER;
      endcase
    end
    seq_data = d;
  endfunction

  assign op_ready = (state_reg == S_IDLE);
  assign take     = op_valid && op_ready;
  // While identified, only reads, verify, reset and hardware reset are sent
  assign refuse   = take && ((id_mode && op_code == OP_ENTER_ID) || op_code > OP_HW_RESET);

  // Two-stage synchroniser for the data pins
  always_ff @(posedge clk) begin
    if (rst) begin
      dq_meta_reg <= 16'h0000;
      dq_sync_reg <= 16'h0000;
    end else begin
      dq_meta_reg <= flash_dq_in;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  // Timer loads per state entry
  always_comb begin
    tmr_start = 1'b0;
    tmr_load  = SETUP_CYC;
    unique case (state_reg)
      S_IDLE: begin
        tmr_start = take && !refuse;
        tmr_load  = (op_code == OP_HW_RESET) ? RP_CYC : SETUP_CYC;
      end
      S_SETUP: begin
        tmr_start = tmr_done;
        tmr_load  = (nwr_reg == 2'h0) ? ACC_CYC : WP_CYC;
      end
      S_STROBE: begin
        tmr_start = tmr_done;
        tmr_load  = RECOV_CYC;
      end
      S_RECOV: begin
        tmr_start = tmr_done;
        tmr_load  = SETUP_CYC;
      end
      S_RST: begin
        tmr_start = tmr_done;
        tmr_load  = RH_CYC;
      end
      S_RDWAIT, S_RSTREC: begin
        tmr_start = 1'b0;
        tmr_load  = SETUP_CYC;
      end
    endcase
  end

  // Main sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg    <= S_IDLE;
      op_reg       <= OP_READ;
      step_reg     <= 2'h0;
      nwr_reg      <= 2'h0;
      rd_after_reg <= 1'b0;
      rd_addr_reg  <= '0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (take && !refuse) begin
            op_reg   <= op_t'(op_code);
            step_reg <= 2'h0;
            rd_addr_reg <= op_addr;
            if (op_code == OP_VERIFY) begin
              rd_addr_reg[7:0] <= word_mode ? OFS_GUARD_WORD : OFS_GUARD_BYTE;
            end
            unique case (op_code)
              OP_ENTER_ID: begin
                nwr_reg      <= ENTER_WRITES;
                rd_after_reg <= 1'b0;
                state_reg    <= S_SETUP;
              end
              OP_RESET: begin
                nwr_reg      <= RESET_WRITES;
                rd_after_reg <= 1'b0;
                state_reg    <= S_SETUP;
              end
              OP_HW_RESET: begin
                nwr_reg      <= 2'h0;
                rd_after_reg <= 1'b0;
                state_reg    <= S_RST;
              end
              default: begin
                nwr_reg      <= 2'h0;
                rd_after_reg <= 1'b1;
                state_reg    <= S_SETUP;
              end
            endcase
          end
        end
        S_SETUP: begin
          if (tmr_done) begin
            state_reg <= (nwr_reg == 2'h0) ? S_RDWAIT : S_STROBE;
          end
        end
        S_STROBE: begin
          if (tmr_done) begin
            state_reg <= S_RECOV;
          end
        end
        S_RECOV: begin
          if (tmr_done) begin
            step_reg <= step_reg + 2'h1;
            nwr_reg  <= nwr_reg - 2'h1;
            if (nwr_reg == 2'h1 && !rd_after_reg) begin
              state_reg <= S_IDLE;
            end else begin
              state_reg <= S_SETUP;
            end
          end
        end
        S_RDWAIT: begin
          if (tmr_done) begin
            state_reg <= S_IDLE;
          end
        end
        S_RST: begin
          if (tmr_done) begin
            state_reg <= S_RSTREC;
          end
        end
        S_RSTREC: begin
          if (tmr_done) begin
            state_reg <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Pin drive from state; strobes registered
  always_ff @(posedge clk) begin
    if (rst) begin
      flash_addr    <= '0;
      flash_dq_out  <= 16'h0000;
      flash_dq_oe   <= 1'b0;
      flash_ce_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_reset_n <= 1'b1;
      flash_byte_n  <= 1'b1;
      high_voltage_select_pin <= 1'b0;
    end else begin
      flash_byte_n  <= word_mode;
      high_voltage_select_pin <= hv_id_en;
      flash_reset_n <= !(state_reg == S_RST);
      flash_ce_n    <= !(state_reg == S_SETUP || state_reg == S_STROBE || state_reg == S_RDWAIT);
      flash_we_n    <= !(state_reg == S_STROBE);
      flash_oe_n    <= !(state_reg == S_RDWAIT);
      flash_dq_oe   <= (state_reg == S_SETUP || state_reg == S_STROBE) && nwr_reg != 2'h0;
      if (state_reg == S_SETUP && nwr_reg != 2'h0) begin
        flash_addr   <= seq_addr(step_reg, word_mode, op_reg);
        flash_dq_out <= {8'h00, seq_data(step_reg, op_reg)};
      end else if (state_reg == S_SETUP) begin
        flash_addr   <= rd_addr_reg;
      end
    end
  end

  // Answer word and identification tracking
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_data  <= 16'h0000;
      rsp_err   <= 1'b0;
      id_mode   <= 1'b0;
      fail_seen <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (refuse) begin
        rsp_valid <= 1'b1;
        rsp_err   <= 1'b1;
      end else if (state_reg == S_RDWAIT && tmr_done) begin
        rsp_valid <= 1'b1;
        rsp_err   <= 1'b0;
        rsp_data  <= word_mode ? dq_sync_reg : {8'h00, dq_sync_reg[7:0]};
        if (!id_mode && !hv_id_en && dq_sync_reg[FAIL_FLAG_BIT]) begin
          fail_seen <= 1'b1;
        end
      end else if (state_reg == S_RECOV && tmr_done && nwr_reg == 2'h1 && !rd_after_reg) begin
        rsp_valid <= 1'b1;
        rsp_err   <= 1'b0;
        if (op_reg == OP_ENTER_ID) begin
          id_mode <= 1'b1;
        end else begin
          id_mode   <= 1'b0;
          fail_seen <= 1'b0;
        end
      end else if (state_reg == S_RSTREC && tmr_done) begin
        rsp_valid <= 1'b1;
        rsp_err   <= 1'b0;
        id_mode   <= 1'b0;
        fail_seen <= 1'b0;
      end
    end
  end

  // Record the last two write data bytes for checking the entry order
  always_ff @(posedge clk) begin
    if (rst) begin
      last_wr_reg <= 8'h00;
      prev_wr_reg <= 8'h00;
    end else if (state_reg == S_STROBE && tmr_done) begin
      last_wr_reg <= flash_dq_out[7:0];
      prev_wr_reg <= last_wr_reg;
    end
  end

  sequence seq_unlocks;
    last_wr_reg == UNLOCK2_DATA && prev_wr_reg == UNLOCK1_DATA;
  endsequence

  property p_entry_order;
    @(posedge clk) disable iff (rst)
      $fell(flash_we_n) && flash_dq_out[7:0] == CMD_ID_ENTER |-> seq_unlocks;
  endproperty
  AST_ENTRY_ORDER: assert property (p_entry_order) else $error("Command 90h sent without both unlocks");

  AST_READ_NO_WRITE: assert property (@(posedge clk) disable iff (rst)
    !flash_oe_n |-> flash_we_n && !flash_dq_oe)
    else $error("Read cycle overlaps a write");

  AST_RESET_CLEARS: assert property (@(posedge clk) disable iff (rst)
    $fell(flash_we_n) && flash_dq_out[7:0] == CMD_RESET |-> ##[1:40] !fail_seen && !id_mode)
    else $error("Reset write did not clear mode flags");

  AST_HW_RESET_LEN: assert property (@(posedge clk) disable iff (rst)
    $fell(flash_reset_n) |-> !flash_reset_n [*8])
    else $error("Hardware reset pulse too short");

endmodule

//--- verilog/flash_id_pkg.sv
// Constants, opcodes and timings for the flash identification and reset host
// Assumes a parallel NOR flash on the far side with asynchronous bus cycles
package flash_id_pkg;

  typedef enum logic [2:0] {
    OP_ENTER_ID = 3'h0,
    OP_READ     = 3'h1,
    OP_VERIFY   = 3'h2,
    OP_RESET    = 3'h3,
    OP_HW_RESET = 3'h4
  } op_t;

  // Command bus cycles, word and byte addressing
  localparam logic [11:0] UNLOCK1_WORD = 12'h0555;
  localparam logic [11:0] UNLOCK2_WORD = 12'h02AA;
  localparam logic [11:0] UNLOCK1_BYTE = 12'h0AAA;
  localparam logic [11:0] UNLOCK2_BYTE = 12'h0555;
  localparam logic [7:0]  UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
  localparam logic [7:0]  CMD_ID_ENTER = 8'h90;
  localparam logic [7:0]  CMD_RESET    = 8'hF0;

  // Identification offsets
  localparam logic [7:0] OFS_MAKER       = 8'h00;
  localparam logic [7:0] OFS_PART1_WORD  = 8'h01;
  localparam logic [7:0] OFS_PART2_WORD  = 8'h0E;
  localparam logic [7:0] OFS_PART3_WORD  = 8'h0F;
  localparam logic [7:0] OFS_PART1_BYTE  = 8'h02;
  localparam logic [7:0] OFS_PART2_BYTE  = 8'h1C;
  localparam logic [7:0] OFS_PART3_BYTE  = 8'h1E;
  localparam logic [7:0] OFS_SECREG_WORD = 8'h03;
  localparam logic [7:0] OFS_SECREG_BYTE = 8'h06;
  localparam logic [7:0] OFS_GUARD_WORD  = 8'h02;
  localparam logic [7:0] OFS_GUARD_BYTE  = 8'h04;

  // Mode-lock word fields and the fail flag bit of read data
  localparam int LOCKW_SECREG_BIT = 0;
  localparam int LOCKW_NVMETH_BIT = 1;
  localparam int LOCKW_PWMETH_BIT = 2;
  localparam int FAIL_FLAG_BIT    = 5;

  // Bus timing in ns and derived counts at 125 MHz
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_SETUP_NS    = 20;
  localparam int T_WP_NS       = 50;
  localparam int T_RECOV_NS    = 30;
  localparam int T_ACC_NS      = 100;
  localparam int T_RP_NS       = 500;
  localparam int T_RH_NS       = 200;
  localparam int SYNC_STAGES   = 2;
  localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WP_CYC    = 8'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RECOV_CYC = 8'((T_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] ACC_CYC   = 8'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
  localparam logic [7:0] RP_CYC    = 8'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RH_CYC    = 8'((T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [1:0] ENTER_WRITES = 2'h3;
  localparam logic [1:0] RESET_WRITES = 2'h1;

endpackage

//--- verilog/cycle_timer.sv
// Down counter that times one phase of a flash bus cycle
// Assumes start is a one-cycle pulse from logic on the same clock
`timescale 1ns/100ps
module cycle_timer (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] load,
  output logic            done
);

  logic [7:0] count_reg;
  logic       run_reg;

  // Count down the loaded figure, flag the last cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= 8'h00;
      run_reg   <= 1'b0;
    end else if (start) begin
      count_reg <= (load == 8'h00) ? 8'h00 : load - 8'h01;
      run_reg   <= 1'b1;
    end else if (run_reg && count_reg != 8'h00) begin
      count_reg <= count_reg - 8'h01;
    end else begin
      run_reg <= 1'b0;
    end
  end

  assign done = run_reg && (count_reg == 8'h00);

endmodule

//--- tb/flash_model.sv
// Behavioural flash device answering the identification host's pins
// Assumes writes latch on the write strobe and reads while chip and output enables are low
`timescale 1ns/100ps
module flash_model #(
  parameter logic [7:0]  MAKER   = 8'h4B,    // Arbitrary value
  parameter logic [15:0] PART1   = 16'h1A0B, // Arbitrary value
  parameter logic [15:0] PART2   = 16'h1A16, // Arbitrary value
  parameter logic [15:0] PART3   = 16'h1A07, // Arbitrary value
  parameter logic [3:0]  GUARDED = 4'h3
) (
  input  wire logic [21:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_reset_n,
  input  wire logic        flash_byte_n,
  input  wire logic        high_voltage_select_pin,
  input  wire logic        fail_inject,
  output logic      [15:0] flash_dq_in
);
  logic [1:0]  cnt;
  logic        id_reg, fail_reg, guard_lock, wsel, sect_prot;
  logic [15:0] nv_guard, vol_guard, tmp_unguard, rd_val, last_val;
  logic [11:0] wa;
  logic [7:0]  wd, ofs;
  assign ofs = flash_addr[7:0];
  // Sector status from its three guard bits
  assign sect_prot = !vol_guard[flash_addr[15:12]] ||
                     (!nv_guard[flash_addr[15:12]] && tmp_unguard[flash_addr[15:12]]);
  // One sector was guarded in an earlier session; the rest stay as shipped
  initial begin
    cnt = 2'h0; id_reg = 1'b0; fail_reg = 1'b0; guard_lock = 1'b0;
    nv_guard = 16'hFFFF; nv_guard[GUARDED] = 1'b0;
    vol_guard = 16'hFFFF; tmp_unguard = 16'hFFFF;
  end
  // Address and data are captured on the falling edge of the write strobe
  always @(negedge flash_we_n) begin
    wsel = !flash_ce_n; wa = flash_addr[11:0]; wd = flash_dq_out[7:0];
  end
  // Command decoding; the hardware reset pin forces read mode
  always @(posedge flash_we_n or posedge fail_inject or negedge flash_reset_n) begin
    if (!flash_reset_n) begin
      cnt = 2'h0; id_reg = 1'b0; fail_reg = 1'b0; guard_lock = 1'b1;
      vol_guard = 16'hFFFF; tmp_unguard = 16'hFFFF;
    end else if (fail_inject && !fail_reg) begin
      fail_reg = 1'b1;
    end else if (wsel) begin
      wsel = 1'b0;
      if (wd == 8'hF0) begin
        cnt = 2'h0; id_reg = 1'b0; fail_reg = 1'b0;
      end else if (id_reg) begin
        cnt = 2'h0;
      end else if (cnt == 2'h0 && wd == 8'hAA && wa == (flash_byte_n ? 12'h555 : 12'hAAA)) begin
        cnt = 2'h1;
      end else if (cnt == 2'h1 && wd == 8'h55 && wa == (flash_byte_n ? 12'h2AA : 12'h555)) begin
        cnt = 2'h2;
      end else if (cnt == 2'h2 && wd == 8'h90) begin
        id_reg = 1'b1; cnt = 2'h0;
      end else begin
        cnt = 2'h0;
      end
    end
  end
  // Read data: array, fail status or identification codes
  always_comb begin
    rd_val = fail_reg ? 16'h0020 : {flash_addr[15:8], 8'h41};
    if (id_reg || high_voltage_select_pin) begin
      rd_val = 16'h0000;
      case ({flash_byte_n, ofs})
        9'h100, 9'h000: rd_val = {8'h00, MAKER};
        9'h101:         rd_val = PART1;
        9'h10E:         rd_val = PART2;
        9'h10F:         rd_val = PART3;
        9'h002:         rd_val = {8'h00, PART1[7:0]};
        9'h01C:         rd_val = {8'h00, PART2[7:0]};
        9'h01E:         rd_val = {8'h00, PART3[7:0]};
        9'h103, 9'h006: rd_val = 16'h0099;
        9'h102, 9'h004: rd_val = {15'h0000, sect_prot};
        default:        rd_val = 16'h0000;
      endcase
    end
  end
  // A deselected device shows the inverse of its last value
  always @(flash_ce_n, flash_oe_n, rd_val) begin
    if (!flash_ce_n && !flash_oe_n) begin
      flash_dq_in = rd_val; last_val = rd_val;
    end else begin
      flash_dq_in = ~last_val;
    end
  end
endmodule

//--- tb/flash_id_host_bench.sv
// Self-checking bench for the flash identification host
// Assumes the behavioural flash model stands on the pin side
`timescale 1ns/100ps
module flash_id_host_bench;
  import flash_id_pkg::*;
  localparam logic [15:0] MK = 16'h004B, P1 = 16'h1A0B, P2 = 16'h1A16, P3 = 16'h1A07;
  localparam logic [21:0] GS = 22'h00_3000, US = 22'h00_5000, AR = 22'h00_1200;
  logic        clk, rst, op_valid, op_ready, word_mode, hv_id_en, rsp_valid, rsp_err, id_mode, fail_seen;
  logic        flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n, flash_byte_n, hv_pin, fail_inject;
  logic [2:0]  op_code;
  logic [21:0] op_addr, flash_addr;
  logic [15:0] rsp_data, flash_dq_out, flash_dq_in, got_data;
  logic        got_err;
  int          err_total, n_tests;

  flash_id_host #(.ADDR_W(22)) flash_id_host_i (
    .clk(clk), .rst(rst), .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
    .op_addr(op_addr), .word_mode(word_mode), .hv_id_en(hv_id_en), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_err(rsp_err), .id_mode(id_mode), .fail_seen(fail_seen),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_reset_n(flash_reset_n), .flash_byte_n(flash_byte_n), .high_voltage_select_pin(hv_pin));

  flash_model flash_model_i (
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_reset_n(flash_reset_n), .flash_byte_n(flash_byte_n),
    .high_voltage_select_pin(hv_pin), .fail_inject(fail_inject), .flash_dq_in(flash_dq_in));

  // Clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic close_out();
    $display("compares %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: data %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  // One user request, held until taken, then waits for its answer
  task automatic run_op(input logic [2:0] c, input logic [21:0] a);
    int n;
    n = 0;
    @(posedge clk);
    op_code <= c; op_addr <= a; op_valid <= 1'b1;
    @(posedge clk);
    while (op_ready !== 1'b1 && n < 100) begin n++; @(posedge clk); end
    op_valid <= 1'b0;
    n = 0;
    @(posedge clk);
    while (rsp_valid !== 1'b1 && n < 400) begin n++; @(posedge clk); end
    if (n == 400) begin
      err_total++;
      $display("unexpected at %0t: no answer", $time);
    end
    got_data = rsp_data; got_err = rsp_err;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [2:0] c, input logic [21:0] a, input logic [15:0] exp);
    run_op(c, a);
    cmp16(got_data, exp);
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("unexpected at %0t: run timed out", $time);
    close_out();
  end

  initial begin
    err_total = 0; n_tests = 0; rst = 1'b1; op_valid = 1'b0; op_code = 3'h0; op_addr = '0;
    word_mode = 1'b1; hv_id_en = 1'b0; fail_inject = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp1(flash_ce_n & flash_oe_n & flash_we_n & flash_reset_n & !flash_dq_oe, 1'b1);
    cmp1(id_mode, 1'b0);
    cmp1(op_ready, 1'b1);
    $display("test reset done");
    run_op(OP_ENTER_ID, '0); cmp1(id_mode, 1'b1);
    rd_chk(OP_READ, 22'h00_0000, MK);
    rd_chk(OP_READ, 22'h00_0100, MK);
    rd_chk(OP_READ, 22'h00_0001, P1);
    rd_chk(OP_READ, 22'h00_000E, P2);
    rd_chk(OP_READ, 22'h00_000F, P3);
    rd_chk(OP_READ, 22'h00_0003, 16'h0099);
    rd_chk(OP_READ, 22'h00_0000, MK);
    rd_chk(OP_VERIFY, GS, 16'h0001);
    rd_chk(OP_VERIFY, US, 16'h0000);
    run_op(OP_ENTER_ID, '0); cmp1(got_err, 1'b1);
    run_op(3'h5, '0); cmp1(got_err, 1'b1);
    run_op(OP_RESET, '0); cmp1(id_mode, 1'b0);
    rd_chk(OP_READ, AR, 16'h1241);
    $display("test word identification done");
    word_mode <= 1'b0;
    run_op(OP_ENTER_ID, '0); cmp1(got_err, 1'b0);
    rd_chk(OP_READ, 22'h00_0000, MK);
    rd_chk(OP_READ, 22'h00_0002, {8'h00, P1[7:0]});
    rd_chk(OP_READ, 22'h00_001C, {8'h00, P2[7:0]});
    rd_chk(OP_READ, 22'h00_001E, {8'h00, P3[7:0]});
    rd_chk(OP_READ, 22'h00_0006, 16'h0099);
    rd_chk(OP_VERIFY, GS, 16'h0001);
    run_op(OP_RESET, '0);
    rd_chk(OP_READ, AR, 16'h0041);
    $display("test byte identification done");
    word_mode <= 1'b1; hv_id_en <= 1'b1;
    rd_chk(OP_READ, 22'h00_0000, MK);
    cmp1(hv_pin, 1'b1);
    hv_id_en <= 1'b0;
    rd_chk(OP_READ, AR, 16'h1241);
    $display("test high voltage done");
    fail_inject <= 1'b1;
    rd_chk(OP_READ, AR, 16'h0020);
    cmp1(fail_seen, 1'b1);
    fail_inject <= 1'b0;
    run_op(OP_RESET, '0); cmp1(fail_seen, 1'b0);
    rd_chk(OP_READ, AR, 16'h1241);
    $display("test fail recovery done");
    run_op(OP_ENTER_ID, '0); cmp1(id_mode, 1'b1);
    cmp1(flash_model_i.guard_lock, 1'b0);
    run_op(OP_HW_RESET, '0); cmp1(id_mode, 1'b0);
    cmp1(flash_model_i.guard_lock, 1'b1);
    rd_chk(OP_READ, AR, 16'h1241);
    $display("test hardware reset done");
    close_out();
  end
endmodule
